// file: inc/ccd_pkg.sv
/*
 * Shared constants and types for the channel clock divider and delay block:
 * divider codes, field widths, reset values and the configuration structs.
 * Assumes a configuration register file elsewhere presents the field values.
 */
// Contract
// - divide input clock by 2,4,6,8,12,16 per 3-bit code; 111 undefined.
// - code 000 passes clock undivided; bypass flag excludes divider from init.
// - channel power-down 1 stops whole channel, 0 keeps it; resets to 0.
// - each output has own power-down bit, 1 stops it; resets to 0.
// - 8-bit phase delay counts input periods, 0 to 255; resets to 0.
// - each output holds 2-bit amplitude, reset 00, read with its style bit.
// - each output enable resets to 0; 0 holds output low, 1 toggles.
package ccd_pkg;

	localparam int DIV_W   = 3;
	localparam int PHASE_W = 8;
	localparam int AMP_W   = 2;
	localparam int HALF_W  = 4;
	localparam int NUM_OUT = 3;

	// divider codes
	localparam logic [DIV_W-1:0] DIV_BYPASS = 3'h0;
	localparam logic [DIV_W-1:0] DIV_BY2    = 3'h1;
	localparam logic [DIV_W-1:0] DIV_BY4    = 3'h2;
	localparam logic [DIV_W-1:0] DIV_BY6    = 3'h3;
	localparam logic [DIV_W-1:0] DIV_BY8    = 3'h4;
	localparam logic [DIV_W-1:0] DIV_BY12   = 3'h5;
	localparam logic [DIV_W-1:0] DIV_BY16   = 3'h6;
	localparam logic [DIV_W-1:0] DIV_UNDEF  = 3'h7;

	// reset values
	localparam logic [DIV_W-1:0]   RST_DIV   = 3'h0;
	localparam logic [PHASE_W-1:0] RST_PHASE = 8'h00;
	localparam logic               RST_PD    = 1'h0;
	localparam logic               RST_STYLE = 1'h0;
	localparam logic [AMP_W-1:0]   RST_AMP   = 2'h0;
	localparam logic               RST_EN    = 1'h0;

	typedef struct packed {
		logic [DIV_W-1:0]   div_sel;
		logic [PHASE_W-1:0] phase;
		logic               pd;
	} ccd_chan_cfg_type;

	typedef struct packed {
		logic             pd;
		logic             style;   // 0 differential low-voltage, 1 emitter-coupled
		logic [AMP_W-1:0] amp;
		logic             en;
	} ccd_out_cfg_type;

	typedef struct packed {
		logic             style;
		logic [AMP_W-1:0] amp;
	} ccd_drive_type;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} ccd_state_type;

	localparam ccd_chan_cfg_type RST_CHAN = '{div_sel: RST_DIV, phase: RST_PHASE, pd: RST_PD};
	localparam ccd_out_cfg_type  RST_OUT  =
		'{pd: RST_PD, style: RST_STYLE, amp: RST_AMP, en: RST_EN};

	// half output period in input cycles for each divider code
	function automatic logic [HALF_W-1:0] div_half(input logic [DIV_W-1:0] sel);
		logic [HALF_W-1:0] h;
		h = 4'h1;
		case (sel)
			DIV_BY2:  h = 4'h1;
			DIV_BY4:  h = 4'h2;
			DIV_BY6:  h = 4'h3;
			DIV_BY8:  h = 4'h4;
			DIV_BY12: h = 4'h6;
			DIV_BY16: h = 4'h8;
			default:  h = 4'h1;
		endcase
		return h;
	endfunction

endpackage

// file: verilog/ccd_phase_div.sv
/*
 * Phase delay and frequency divider core for one channel.
 * Assumes restart is a one-cycle pulse from the channel wrapper and that
 * div_sel and phase stay put while running unless restart accompanies a change.
 */
`timescale 1ns/1ps
`default_nettype none

module ccd_phase_div (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         run,
	input  wire logic                         restart,
	input  wire logic [ccd_pkg::DIV_W-1:0]    div_sel,
	input  wire logic [ccd_pkg::PHASE_W-1:0]  phase,
	output logic                              div_clk_ff,
	output logic                              running_ff
);

	ccd_pkg::ccd_state_type              state_ff;
	ccd_pkg::ccd_state_type              nxt_state;
	logic [ccd_pkg::PHASE_W-1:0]         cnt_ff;
	logic [ccd_pkg::PHASE_W-1:0]         nxt_cnt;
	logic [ccd_pkg::HALF_W-1:0]          hcnt_ff;
	logic [ccd_pkg::HALF_W-1:0]          nxt_hcnt;
	logic [ccd_pkg::HALF_W-1:0]          half;
	logic [ccd_pkg::HALF_W-1:0]          since_ff;
	logic [ccd_pkg::PHASE_W-1:0]         dly_seen_ff;
	logic                                nxt_div;

	// sequencer: wait phase cycles, then divide
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_hcnt  = hcnt_ff;
		nxt_div   = div_clk_ff;
		half      = ccd_pkg::div_half(div_sel);
		case (state_ff)
			ccd_pkg::ST_IDLE:
			begin
				nxt_div = 1'b0;
				if (run && div_sel != ccd_pkg::DIV_UNDEF)
				begin
					if (phase == 8'h00)
					begin
						nxt_state = ccd_pkg::ST_RUN;
						nxt_div   = 1'b1;
						nxt_hcnt  = 4'(half - 4'h1);
					end
					else
					begin
						nxt_state = ccd_pkg::ST_DELAY;
						nxt_cnt   = 8'(phase - 8'h01);
					end
				end
			end
			ccd_pkg::ST_DELAY:
			begin
				if (cnt_ff == 8'h00)
				begin
					nxt_state = ccd_pkg::ST_RUN;
					nxt_div   = 1'b1;
					nxt_hcnt  = 4'(half - 4'h1);
				end
				else
					nxt_cnt = 8'(cnt_ff - 8'h01);
			end
			default:
			begin
				// bypass holds the pass gate open
				if (div_sel == ccd_pkg::DIV_BYPASS)
					nxt_div = 1'b1;
				else if (hcnt_ff == 4'h0)
				begin
					nxt_div  = ~div_clk_ff;
					nxt_hcnt = 4'(half - 4'h1);
				end
				else
					nxt_hcnt = 4'(hcnt_ff - 4'h1);
			end
		endcase
		if (!run || restart)
		begin
			nxt_state = ccd_pkg::ST_IDLE;
			nxt_div   = 1'b0;
		end
	end

	// state registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff   <= ccd_pkg::ST_IDLE;
			cnt_ff     <= 8'h00;
			hcnt_ff    <= 4'h0;
			div_clk_ff <= 1'b0;
			running_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			hcnt_ff    <= nxt_hcnt;
			div_clk_ff <= nxt_div;
			running_ff <= (nxt_state == ccd_pkg::ST_RUN);
		end
	end

	// helper counters for checks only
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			since_ff    <= 4'h0;
			dly_seen_ff <= 8'h00;
		end
		else
		begin
			since_ff    <= (nxt_div != div_clk_ff || nxt_state != ccd_pkg::ST_RUN) ?
				4'h0 : 4'(since_ff + 4'h1);
			dly_seen_ff <= (state_ff == ccd_pkg::ST_DELAY) ? 8'(dly_seen_ff + 8'h01) : 8'h00;
		end
	end

	chk_half_period: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_ff == ccd_pkg::ST_RUN && nxt_state == ccd_pkg::ST_RUN && nxt_div != div_clk_ff)
		|-> since_ff == 4'(half - 4'h1))
		else $error("divided clock half period wrong");

	chk_bypass_pass: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_ff == ccd_pkg::ST_RUN && div_sel == ccd_pkg::DIV_BYPASS) |-> div_clk_ff)
		else $error("bypass gate not open");

	chk_undef_idle: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_ff == ccd_pkg::ST_IDLE && div_sel == ccd_pkg::DIV_UNDEF)
		|=> state_ff == ccd_pkg::ST_IDLE && !div_clk_ff)
		else $error("undefined code started divider");

	chk_delay_len: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_ff == ccd_pkg::ST_DELAY && nxt_state == ccd_pkg::ST_RUN)
		|-> 8'(dly_seen_ff + 8'h01) == phase)
		else $error("phase delay length wrong");

	chk_zero_delay: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_ff == ccd_pkg::ST_IDLE && run && !restart && phase == 8'h00
			&& div_sel != ccd_pkg::DIV_UNDEF)
		|=> state_ff == ccd_pkg::ST_RUN ##0 div_clk_ff)
		else $error("zero delay did not start at once");

endmodule // ccd_phase_div

`default_nettype wire

// file: verilog/ccd_channel.sv
/*
 * One clock fanout channel: configuration registers, restart control,
 * divider with phase delay, and per-output gating and drive settings.
 * Assumes the serial configuration logic presents field values with a
 * one-cycle write strobe, and that analog drivers consume the drive codes.
 */
`timescale 1ns/1ps
`default_nettype none

module ccd_channel #(
	parameter int NUM_OUT = ccd_pkg::NUM_OUT
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic                     cfg_we,
	input  wire ccd_pkg::ccd_chan_cfg_type chan_cfg_in,
	input  wire ccd_pkg::ccd_out_cfg_type  out_cfg_in [NUM_OUT],
	input  wire logic                     bypass_divider_init,
	input  wire logic                     div_init,
	output ccd_pkg::ccd_chan_cfg_type     chan_cfg_ff,
	output ccd_pkg::ccd_out_cfg_type      out_cfg_ff [NUM_OUT],
	output logic [NUM_OUT-1:0]            clock_output_ff,
	output ccd_pkg::ccd_drive_type        out_drive_ff [NUM_OUT],
	output logic                          channel_running_ff
);

	ccd_pkg::ccd_chan_cfg_type  nxt_chan_cfg;
	ccd_pkg::ccd_out_cfg_type   nxt_out_cfg [NUM_OUT];
	ccd_pkg::ccd_drive_type     nxt_drive [NUM_OUT];
	logic [NUM_OUT-1:0]         nxt_clock_output;
	logic                       restart;
	logic                       cfg_change;
	logic                       init_hit;
	logic                       div_clk;
	logic                       div_running;
	logic                       nxt_channel_running;

	// channel register next value
	always_comb
	begin
		nxt_chan_cfg = chan_cfg_ff;
		if (cfg_we)
			nxt_chan_cfg = chan_cfg_in;
	end

	// channel register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			chan_cfg_ff <= ccd_pkg::RST_CHAN;
		else
			chan_cfg_ff <= nxt_chan_cfg;
	end

	// restart on divider or delay change, or on divider init
	always_comb
	begin
		cfg_change = cfg_we && (chan_cfg_in.div_sel != chan_cfg_ff.div_sel ||
			chan_cfg_in.phase != chan_cfg_ff.phase);
		// bypass flag keeps divider out of init
		init_hit   = div_init && !bypass_divider_init;
		restart    = cfg_change || init_hit;
	end

	ccd_phase_div u_phase_div (
		.clk        (clk),
		.arst_n     (arst_n),
		.run        (!chan_cfg_ff.pd),
		.restart    (restart),
		.div_sel    (chan_cfg_ff.div_sel),
		.phase      (chan_cfg_ff.phase),
		.div_clk_ff (div_clk),
		.running_ff (div_running)
	);

	// channel status
	always_comb
	begin
		nxt_channel_running = div_running && !chan_cfg_ff.pd;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			channel_running_ff <= 1'b0;
		else
			channel_running_ff <= nxt_channel_running;
	end

	generate
		for (genvar i = 0; i < NUM_OUT; i++)
		begin : g_out
			// output register next value
			always_comb
			begin
				nxt_out_cfg[i] = out_cfg_ff[i];
				if (cfg_we)
					nxt_out_cfg[i] = out_cfg_in[i];
			end

			// output gating and drive code
			always_comb
			begin
				nxt_clock_output[i] = div_clk && div_running && !chan_cfg_ff.pd &&
					!out_cfg_ff[i].pd && out_cfg_ff[i].en;
				nxt_drive[i].style = out_cfg_ff[i].style;
				nxt_drive[i].amp   = out_cfg_ff[i].amp;
			end

			// output registers
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					out_cfg_ff[i]       <= ccd_pkg::RST_OUT;
					clock_output_ff[i]  <= 1'b0;
					out_drive_ff[i]     <= '{style: ccd_pkg::RST_STYLE, amp: ccd_pkg::RST_AMP};
				end
				else
				begin
					out_cfg_ff[i]       <= nxt_out_cfg[i];
					clock_output_ff[i]  <= nxt_clock_output[i];
					out_drive_ff[i]     <= nxt_drive[i];
				end
			end

			chk_out_pd: assert property (
				@(posedge clk) disable iff (!arst_n)
				out_cfg_ff[i].pd |=> !clock_output_ff[i])
				else $error("powered-down output toggles");

			chk_out_en: assert property (
				@(posedge clk) disable iff (!arst_n)
				!out_cfg_ff[i].en |=> !clock_output_ff[i])
				else $error("disabled output not held low");

			chk_out_follow: assert property (
				@(posedge clk) disable iff (!arst_n)
				(out_cfg_ff[i].en && !out_cfg_ff[i].pd && !chan_cfg_ff.pd && div_running)
				|=> clock_output_ff[i] == $past(div_clk))
				else $error("enabled output does not follow divider");

			chk_drive_amp: assert property (
				@(posedge clk) disable iff (!arst_n)
				1'b1 |=> out_drive_ff[i].amp == $past(out_cfg_ff[i].amp)
					&& out_drive_ff[i].style == $past(out_cfg_ff[i].style))
				else $error("drive code does not track amplitude and style");

			chk_out_load: assert property (
				@(posedge clk) disable iff (!arst_n)
				cfg_we
				|=> out_cfg_ff[i] == $past(out_cfg_in[i]))
				else $error("output register did not load");

			chk_out_hold: assert property (
				@(posedge clk) disable iff (!arst_n)
				!cfg_we
				|=> out_cfg_ff[i] == $past(out_cfg_ff[i]))
				else $error("output register changed without a write");

			chk_bypass_level: assert property (
				@(posedge clk) disable iff (!arst_n)
				(chan_cfg_ff.div_sel == ccd_pkg::DIV_BYPASS && div_running && !chan_cfg_ff.pd
					&& !out_cfg_ff[i].pd && out_cfg_ff[i].en)
				|=> clock_output_ff[i])
				else $error("bypassed output not at pass level");
		end
	endgenerate

	chk_chan_pd: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_cfg_ff.pd |=> clock_output_ff == '0 ##1 clock_output_ff == '0)
		else $error("powered-down channel still drives outputs");

	chk_chan_pd_stop: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_cfg_ff.pd |=> !div_running)
		else $error("divider runs in powered-down channel");

	chk_init_skip: assert property (
		@(posedge clk) disable iff (!arst_n)
		(div_init && bypass_divider_init && !cfg_change) |-> !restart)
		else $error("bypassed divider restarted by init");

	chk_init_hit: assert property (
		@(posedge clk) disable iff (!arst_n)
		(div_init && !bypass_divider_init && !chan_cfg_ff.pd) |=> !div_running)
		else $error("divider init did not restart the divider");

	chk_delay_start: assert property (
		@(posedge clk) disable iff (!arst_n)
		(cfg_change && chan_cfg_in.phase == 8'h02 && !chan_cfg_in.pd
			&& chan_cfg_in.div_sel != ccd_pkg::DIV_UNDEF)
		|=> !div_running ##1 !div_running ##1 !div_running ##1 div_running)
		else $error("two-period delay not applied");

	chk_cfg_load: assert property (
		@(posedge clk) disable iff (!arst_n)
		cfg_we
		|=> chan_cfg_ff == $past(chan_cfg_in))
		else $error("channel register did not load");

	chk_cfg_hold: assert property (
		@(posedge clk) disable iff (!arst_n)
		!cfg_we
		|=> chan_cfg_ff == $past(chan_cfg_ff))
		else $error("channel register changed without a write");

	chk_pd_status: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_cfg_ff.pd
		|=> !channel_running_ff)
		else $error("powered-down channel reports running");

	chk_restart_stop: assert property (
		@(posedge clk) disable iff (!arst_n)
		restart
		|=> !div_running)
		else $error("restart did not return divider to idle");

	chk_idle_low: assert property (
		@(posedge clk) disable iff (!arst_n)
		!div_running
		|=> clock_output_ff == '0)
		else $error("outputs toggle while divider idle");

endmodule // ccd_channel

`default_nettype wire

// file: sim/ccd_sink.sv
/*
 * downstream clock sink: counts rises of every clock output and measures
 * the last high and low run of output 0 in input clock cycles.
 * assumes outputs change only on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ccd_sink #(
	parameter int NUM_OUT = 3
) (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic [NUM_OUT-1:0] clock_output,
	output logic [15:0]             rise_cnt [NUM_OUT],
	output logic [15:0]             hi_len,
	output logic [15:0]             lo_len
);
	logic [NUM_OUT-1:0] last;
	logic [15:0]        run;

	// edge counting and run lengths
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			last <= '0;
			run <= 16'h0000;
			hi_len <= 16'h0000;
			lo_len <= 16'h0000;
			for (int i = 0; i < NUM_OUT; i++)
				rise_cnt[i] <= 16'h0000;
		end
		else
		begin
			last <= clock_output;
			for (int i = 0; i < NUM_OUT; i++)
				if (clock_output[i] && !last[i])
					rise_cnt[i] <= rise_cnt[i] + 16'h0001;
			if (clock_output[0] !== last[0])
			begin
				run <= 16'h0001;
				if (last[0])
					hi_len <= run;
				else
					lo_len <= run;
			end
			else
				run <= run + 16'h0001;
		end
	end
endmodule // ccd_sink

`default_nettype wire

// file: sim/channel_clock_divider_delay_test.sv
/*
 * self-checking bench for one channel: reset values, divide table,
 * phase delay latency, bypass, undefined code, power-down and gating.
 * assumes the ccd_sink model watches the clock outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module channel_clock_divider_delay_test;
	localparam int N = ccd_pkg::NUM_OUT;
	logic                      clk = 1'b0;
	logic                      arst_n = 1'b0;
	logic                      cfg_we = 1'b0;
	logic                      bypass_divider_init = 1'b0;
	logic                      div_init = 1'b0;
	ccd_pkg::ccd_chan_cfg_type chan_cfg_in = '0;
	ccd_pkg::ccd_out_cfg_type  out_cfg_in [N];
	ccd_pkg::ccd_chan_cfg_type chan_cfg_ff;
	ccd_pkg::ccd_out_cfg_type  out_cfg_ff [N];
	ccd_pkg::ccd_drive_type    out_drive_ff [N];
	logic [N-1:0]              clock_output_ff;
	logic                      channel_running_ff;
	logic [15:0]               rise_cnt [N];
	logic [15:0]               hi_len;
	logic [15:0]               lo_len;
	int                        fails = 0;
	int                        check_count = 0;
	logic [2:0]                div_tab [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	logic [3:0]                half_tab [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};

	// 250 MHz input clock
	always #2 clk = ~clk;

	ccd_channel #(.NUM_OUT(N)) dut_u (
		.clk(clk), .arst_n(arst_n), .cfg_we(cfg_we), .chan_cfg_in(chan_cfg_in),
		.out_cfg_in(out_cfg_in), .bypass_divider_init(bypass_divider_init),
		.div_init(div_init), .chan_cfg_ff(chan_cfg_ff), .out_cfg_ff(out_cfg_ff),
		.clock_output_ff(clock_output_ff), .out_drive_ff(out_drive_ff),
		.channel_running_ff(channel_running_ff)
	);

	ccd_sink #(.NUM_OUT(N)) sink_u (
		.clk(clk), .arst_n(arst_n), .clock_output(clock_output_ff),
		.rise_cnt(rise_cnt), .hi_len(hi_len), .lo_len(lo_len)
	);

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// write all fields: out0 enabled, out1 powered down, out2 disabled
	task automatic write_cfg(input logic [2:0] d, input logic [7:0] p, input logic pd,
		input logic st, input logic [1:0] am);
		chan_cfg_in = '{div_sel: d, phase: p, pd: pd};
		out_cfg_in[0] = '{pd: 1'b0, style: st, amp: am, en: 1'b1};
		out_cfg_in[1] = '{pd: 1'b1, style: st, amp: am, en: 1'b1};
		out_cfg_in[2] = '{pd: 1'b0, style: st, amp: am, en: 1'b0};
		@(negedge clk);
		cfg_we = 1'b1;
		@(negedge clk);
		cfg_we = 1'b0;
		chk("chan readback", chan_cfg_ff, chan_cfg_in);
		for (int i = 0; i < N; i++)
			chk("out readback", out_cfg_ff[i], out_cfg_in[i]);
		@(negedge clk);
		for (int i = 0; i < N; i++)
			chk("drive code", out_drive_ff[i], {st, am}); // style amp
	endtask

	task automatic wait_rises(input int k);
		logic [15:0] base;
		base = rise_cnt[0];
		for (int i = 0; i < 400 && (rise_cnt[0] - base) < k; i++)
			@(negedge clk);
		chk("rise count", (rise_cnt[0] - base) >= k, 1); // running
		if ((rise_cnt[0] - base) < k)
			tally_and_finish();
	endtask

	// negedges from the one driving div_init to the first that sees output 0 high
	task automatic lat(input int p);
		int cnt;
		div_init = 1'b1;
		cnt = 0;
		for (int i = 0; i < 300; i++)
		begin
			@(negedge clk);
			div_init = 1'b0;
			cnt++;
			if (cnt >= 3 && clock_output_ff[0] === 1'b1)
				break;
		end
		chk("start latency", cnt, p + 3); // delay
		if (clock_output_ff[0] !== 1'b1)
			tally_and_finish();
	endtask

	// watchdog for the whole run
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		logic [15:0] b1;
		logic [15:0] b2;
		for (int i = 0; i < N; i++)
			out_cfg_in[i] = '0;
		repeat (16) @(negedge clk);
		chk("chan reset", chan_cfg_ff, ccd_pkg::RST_CHAN);
		for (int i = 0; i < N; i++)
			chk("out reset", out_cfg_ff[i], ccd_pkg::RST_OUT);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("run after reset", channel_running_ff, 1); // default
		chk("disabled low", clock_output_ff, 0); // enable reset
		for (int r = 0; r < 6; r++)
		begin
			write_cfg(div_tab[r], 8'h00, 1'b0, r[0], r[1:0]);
			b1 = rise_cnt[1];
			b2 = rise_cnt[2];
			wait_rises(3);
			chk("high run", hi_len, half_tab[r]); // half period
			chk("low run", lo_len, half_tab[r]); // half period
			chk("out1 silent", rise_cnt[1], b1); // output down
			chk("out2 silent", rise_cnt[2], b2); // output disabled
		end
		write_cfg(3'h1, 8'h00, 1'b0, 1'b0, 2'h0);
		lat(0);
		write_cfg(3'h1, 8'h05, 1'b0, 1'b0, 2'h0);
		lat(5);
		write_cfg(3'h5, 8'h05, 1'b0, 1'b1, 2'h3);
		lat(5);
		// two-period delay left to finish before the init pulse
		write_cfg(3'h4, 8'h02, 1'b0, 1'b0, 2'h1);
		repeat (2) @(negedge clk);
		lat(2);
		write_cfg(3'h6, 8'hff, 1'b0, 1'b1, 2'h2);
		lat(255);
		write_cfg(3'h0, 8'h00, 1'b0, 1'b0, 2'h1);
		repeat (4) @(negedge clk);
		chk("pass gate", clock_output_ff[0], 1); // undivided
		bypass_divider_init = 1'b1;
		div_init = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			@(negedge clk);
			div_init = 1'b0;
			chk("init ignored", channel_running_ff, 1); // bypass flag
		end
		bypass_divider_init = 1'b0;
		write_cfg(3'h7, 8'h00, 1'b0, 1'b0, 2'h0);
		repeat (8) @(negedge clk);
		chk("undef out", clock_output_ff, 0); // code 111
		chk("undef run", channel_running_ff, 0); // code 111
		write_cfg(3'h1, 8'h00, 1'b1, 1'b0, 2'h0);
		repeat (4) @(negedge clk);
		chk("pd out", clock_output_ff, 0); // channel down
		chk("pd run", channel_running_ff, 0); // channel down
		write_cfg(3'h1, 8'h00, 1'b0, 1'b0, 2'h0);
		wait_rises(2);
		// second reset in mid-run
		arst_n = 1'b0;
		@(negedge clk);
		chk("chan rereset", chan_cfg_ff, ccd_pkg::RST_CHAN); // zero delay
		chk("out rereset", clock_output_ff, 0); // held low
		arst_n = 1'b1;
		@(negedge clk);
		chk("rerun edge1", channel_running_ff, 0); // restart
		@(negedge clk);
		chk("rerun edge2", channel_running_ff, 1); // restart
		chk("rerun low", clock_output_ff, 0); // enable reset
		tally_and_finish();
	end
endmodule // channel_clock_divider_delay_test

`default_nettype wire
